// ===== rtl/gate_drive_ocp_config_regs.sv
// Gate drive and overcurrent configuration bank with lock, written over a serial port.
// Overcurrent inputs and PWM activity arrive asynchronously from the analog side.
// Overview of operation
// - Code 110b while unlocked locks the bank
// - Locked: lock field and control bits 2-0 writable
// - Unlocked: other lock codes change nothing
// - Code 011b unlocks; lock field resets to 011b
// - Locked: codes other than 011b stay locked
// - 0x03 holds lock, source, sink; strengths 1111b
// - 0x04 holds cycle clear, drive time, strengths
// - 0x05 holds retry, dead, mode, filter, threshold
// - Drive time 500/1000/2000/4000 ns, reset 11b
// - Cycle clear ends retry fault on PWM
// - Retry interval 4 ms or 50 us
// - Dead time 100/100/200/400 ns (50 ns rounds up to one cycle), reset 01b
// - Mode 00b latches fault until cleared
// - Mode 01b fault clears after retry interval
// - Mode 10b reports only, drive untouched
// - Mode 11b neither reports nor acts
// - Filter 2/4/6/8 us before recognition
// - Clear bit clears faults, self-resets
// - Float bit puts all switches Hi-Z
`timescale 1ns/1ps
module gate_drive_ocp_config_regs #(
  parameter int RETRY_LONG_CYCLES = gate_drive_pkg::RETRY_LONG_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_OE,
  input wire logic VDS_OVERCURRENT,
  input wire logic SENSE_OVERCURRENT,
  input wire logic PWM_INPUT,
  output logic FAULT_N,
  output logic DRIVE_INHIBIT,
  output logic OUTPUTS_FLOAT,
  output logic BANK_LOCKED,
  output gate_drive_pkg::drive_cfg_s DRIVE_CFG
);
  logic [10:0] ctrl_ff, hs_ff, ls_ff, ocp_ff;
  logic locked_ff;
  logic wr_valid;
  gate_drive_pkg::spi_write_s wr;
  logic [3:0] rd_addr;
  logic [10:0] rd_data;
  logic [2:0] p0_ff, p1_ff, p2_ff, pin_ff;
  logic pwm_prev_ff, pwm_edge;
  logic [1:0] flag_ff, event_hit;
  logic [6:0] filt_cnt_ff [2];
  logic [15:0] timer_ff [2];
  logic [6:0] filt_limit;
  logic [15:0] retry_load;
  gate_drive_pkg::overcurrent_response_select_e mode;
  logic wr_hs, wr_ctrl, unlock_req, clear_req, cbc;

  spi_frame_port u_port (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .cs_n_pin(SPI_CS_N),
    .sclk_pin(SPI_SCLK),
    .sdi_pin(SPI_SDI),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .wr_valid(wr_valid),
    .wr(wr),
    .sdo(SPI_SDO),
    .sdo_oe(SPI_SDO_OE)
  );

  assign wr_hs = wr_valid && wr.addr == gate_drive_pkg::ADDR_HS_DRIVE;
  assign wr_ctrl = wr_valid && wr.addr == gate_drive_pkg::ADDR_DRV_CTRL;
  assign unlock_req = wr_hs && wr.data[gate_drive_pkg::LOCK_LSB +: 3] == gate_drive_pkg::UNLOCK_CODE;
  assign mode = gate_drive_pkg::overcurrent_response_select_e'(ocp_ff[gate_drive_pkg::MODE_LSB +: 2]);
  assign clear_req = ctrl_ff[gate_drive_pkg::CLEAR_BIT];
  assign cbc = ls_ff[gate_drive_pkg::CBC_BIT];
  assign filt_limit = gate_drive_pkg::filter_cycles(ocp_ff[gate_drive_pkg::FILTER_LSB +: 2]);
  // Retry interval select
  assign retry_load = ocp_ff[gate_drive_pkg::RETRY_BIT] ? 16'(gate_drive_pkg::RETRY_SHORT_CYCLES) :
                      16'(RETRY_LONG_CYCLES);

  // Lock state
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      locked_ff <= 1'b0;
    else if (wr_hs)
    begin
      if (!locked_ff && wr.data[gate_drive_pkg::LOCK_LSB +: 3] == gate_drive_pkg::LOCK_CODE)
        locked_ff <= 1'b1;
      else if (locked_ff && unlock_req)
        locked_ff <= 1'b0;
    end
  end

  // Driver control: clear bit self-resets, only low bits writable while locked
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      ctrl_ff <= gate_drive_pkg::CTRL_RESET;
    else if (wr_ctrl && locked_ff)
      ctrl_ff <= {ctrl_ff[10:gate_drive_pkg::CTRL_LOCKED_BITS],
                  wr.data[gate_drive_pkg::CTRL_LOCKED_BITS-1:0]};
    else if (wr_ctrl)
      ctrl_ff <= wr.data;
    else
      ctrl_ff[gate_drive_pkg::CLEAR_BIT] <= 1'b0;
  end

  // High-side strengths and lock field
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      hs_ff <= gate_drive_pkg::HS_RESET;
    else if (wr_hs)
    begin
      hs_ff[gate_drive_pkg::LOCK_LSB +: 3] <= wr.data[gate_drive_pkg::LOCK_LSB +: 3];
      if (!locked_ff)
        hs_ff[7:0] <= wr.data[7:0];
    end
  end

  // Low-side strengths, drive time, cycle clear; overcurrent control
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      ls_ff <= gate_drive_pkg::LS_RESET;
      ocp_ff <= gate_drive_pkg::OCP_RESET;
    end
    else if (wr_valid && !locked_ff)
    begin
      if (wr.addr == gate_drive_pkg::ADDR_LS_DRIVE)
        ls_ff <= wr.data;
      if (wr.addr == gate_drive_pkg::ADDR_OCP_CTRL)
        ocp_ff <= wr.data;
    end
  end

  // Read mux; reads work whether locked or not
  always_comb
  begin
    rd_data = 11'h000;
    unique case (rd_addr)
      gate_drive_pkg::ADDR_FAULT_1:
      begin
        rd_data[gate_drive_pkg::FAULT_ANY_BIT] = |flag_ff;
        rd_data[gate_drive_pkg::FAULT_VDS_BIT] = flag_ff[0];
      end
      gate_drive_pkg::ADDR_FAULT_2: rd_data[gate_drive_pkg::FAULT_SEN_BIT] = flag_ff[1];
      gate_drive_pkg::ADDR_DRV_CTRL: rd_data = ctrl_ff;
      gate_drive_pkg::ADDR_HS_DRIVE: rd_data = hs_ff;
      gate_drive_pkg::ADDR_LS_DRIVE: rd_data = ls_ff;
      gate_drive_pkg::ADDR_OCP_CTRL: rd_data = ocp_ff;
      default: rd_data = 11'h000;
    endcase
  end

  // Pin synchronisers: bit 0 drain-source, bit 1 sense, bit 2 PWM
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      p0_ff <= 3'h0;
      p1_ff <= 3'h0;
      p2_ff <= 3'h0;
    end
    else
    begin
      p0_ff <= {PWM_INPUT, SENSE_OVERCURRENT, VDS_OVERCURRENT};
      p1_ff <= p0_ff;
      p2_ff <= p1_ff;
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_pin
    always_ff @(posedge CLOCK)
    begin
      if (!RESET_N)
        pin_ff[i] <= 1'b0;
      else if (p1_ff[i] == p2_ff[i])
        pin_ff[i] <= p2_ff[i];
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      pwm_prev_ff <= 1'b0;
    else
      pwm_prev_ff <= pin_ff[2];
  end

  assign pwm_edge = pin_ff[2] & ~pwm_prev_ff;

  // Per source: filter, fault flag, retry timer
  for (genvar i = 0; i < 2; i++)
  begin : g_src
    assign event_hit[i] = pin_ff[i] && filt_cnt_ff[i] == filt_limit - 7'h01;

    always_ff @(posedge CLOCK)
    begin
      if (!RESET_N || !pin_ff[i])
        filt_cnt_ff[i] <= 7'h00;
      else if (filt_cnt_ff[i] < filt_limit)
        filt_cnt_ff[i] <= filt_cnt_ff[i] + 7'h01;
    end

    always_ff @(posedge CLOCK)
    begin
      if (!RESET_N)
      begin
        flag_ff[i] <= 1'b0;
        timer_ff[i] <= 16'h0000;
      end
      else if (event_hit[i] && mode != gate_drive_pkg::OCP_IGNORE)
      begin
        flag_ff[i] <= 1'b1;
        timer_ff[i] <= retry_load;
      end
      else if (flag_ff[i])
      begin
        if (clear_req)
          flag_ff[i] <= 1'b0;
        else if (mode == gate_drive_pkg::OCP_RETRY && cbc && pwm_edge)
          flag_ff[i] <= 1'b0;
        else if (mode == gate_drive_pkg::OCP_RETRY)
        begin
          if (timer_ff[i] <= 16'h0001)
            flag_ff[i] <= 1'b0;
          else
            timer_ff[i] <= timer_ff[i] - 16'h0001;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      FAULT_N <= 1'b1;
      DRIVE_INHIBIT <= 1'b0;
      OUTPUTS_FLOAT <= 1'b0;
    end
    else
    begin
      FAULT_N <= ~(|flag_ff);
      DRIVE_INHIBIT <= (|flag_ff) && (mode == gate_drive_pkg::OCP_LATCH
                                      || mode == gate_drive_pkg::OCP_RETRY);
      OUTPUTS_FLOAT <= ctrl_ff[gate_drive_pkg::FLOAT_BIT];
    end
  end

  assign BANK_LOCKED = locked_ff;

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      DRIVE_CFG <= '0;
    else
    begin
      DRIVE_CFG.high_side_source_strength <= hs_ff[gate_drive_pkg::SRC_LSB +: 4];
      DRIVE_CFG.high_side_sink_strength <= hs_ff[gate_drive_pkg::SNK_LSB +: 4];
      DRIVE_CFG.low_side_source_strength <= ls_ff[gate_drive_pkg::SRC_LSB +: 4];
      DRIVE_CFG.low_side_sink_strength <= ls_ff[gate_drive_pkg::SNK_LSB +: 4];
      DRIVE_CFG.peak_current_cycles <= gate_drive_pkg::peak_cycles(ls_ff[gate_drive_pkg::PEAK_LSB +: 2]);
      DRIVE_CFG.dead_time_cycles <= gate_drive_pkg::dead_cycles(ocp_ff[gate_drive_pkg::DEAD_LSB +: 2]);
      DRIVE_CFG.drain_source_threshold_code <= ocp_ff[gate_drive_pkg::THRESH_LSB +: 4];
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  a_lock_enter: assert property (wr_hs && !locked_ff && wr.data[10:8] == 3'h6 |=> locked_ff)
    else $error("lock code did not lock");
  a_locked_ctrl: assert property (wr_ctrl && locked_ff |=> ctrl_ff[10:3] == $past(ctrl_ff[10:3])
    && ctrl_ff[2:0] == $past(wr.data[2:0]))
    else $error("locked control write wrong");
  a_unlocked_other: assert property (wr_hs && !locked_ff && wr.data[10:8] != 3'h6 |=> !locked_ff)
    else $error("other code locked bank");
  a_unlock_code: assert property (locked_ff && unlock_req |=> !locked_ff)
    else $error("unlock code ignored");
  a_locked_stays: assert property (locked_ff && !unlock_req |=> locked_ff)
    else $error("bank unlocked without code");
  a_reset_values: assert property ($rose(RESET_N) |-> hs_ff == 11'h3ff && ls_ff == 11'h7ff
    && ocp_ff == 11'h159 && !locked_ff)
    else $error("reset values wrong");
  a_peak_time: assert property (1'b1 |=> DRIVE_CFG.peak_current_cycles == 6'h05 << $past(ls_ff[9:8]))
    else $error("drive time count wrong");
  a_cbc_clear: assert property (flag_ff[0] && mode == gate_drive_pkg::OCP_RETRY && cbc && pwm_edge
    && !event_hit[0] |=> !flag_ff[0])
    else $error("cycle clear ignored");
  a_retry_load: assert property (event_hit[1] && mode == gate_drive_pkg::OCP_RETRY && ocp_ff[10]
    |=> timer_ff[1] == 16'h01f4 && flag_ff[1])
    else $error("short retry not loaded");
  a_latch_hold: assert property (flag_ff[0] && mode == gate_drive_pkg::OCP_LATCH && !clear_req
    |=> flag_ff[0])
    else $error("latched fault dropped");
  a_retry_expire: assert property (flag_ff[0] && mode == gate_drive_pkg::OCP_RETRY
    && timer_ff[0] == 16'h0001 && !event_hit[0] && !clear_req |=> !flag_ff[0] ##1 FAULT_N || flag_ff[1])
    else $error("retry fault did not expire");
  a_report_free: assert property (mode == gate_drive_pkg::OCP_REPORT |=> !DRIVE_INHIBIT)
    else $error("report mode inhibited drive");
  a_ignore_quiet: assert property (mode == gate_drive_pkg::OCP_IGNORE && flag_ff == 2'h0
    |=> flag_ff == 2'h0)
    else $error("ignore mode raised fault");
  a_filter_wait: assert property (event_hit[0] |-> pin_ff[0] && $past(pin_ff[0], 19)
    && filt_cnt_ff[0] == filt_limit - 7'h01)
    else $error("fault recognised too early");
  a_clear_pulse: assert property (clear_req && event_hit == 2'h0 |=> flag_ff == 2'h0 && !clear_req)
    else $error("clear did not act once");
  a_float_out: assert property (ctrl_ff[2] |=> OUTPUTS_FLOAT)
    else $error("float not driven");
  a_locked_frozen: assert property (locked_ff |=> $stable(ls_ff) && $stable(ocp_ff) && $stable(hs_ff[7:0]))
    else $error("locked field changed");

  c_lock_cycle: cover property (locked_ff ##[1:1000] !locked_ff);
  c_retry_expiry: cover property (flag_ff[0] && mode == gate_drive_pkg::OCP_RETRY ##1 !flag_ff[0]);
  c_latched: cover property (flag_ff[1] && mode == gate_drive_pkg::OCP_LATCH && DRIVE_INHIBIT);
  c_cbc: cover property (flag_ff[0] && cbc && pwm_edge);

endmodule : gate_drive_ocp_config_regs

// ===== include/gate_drive_pkg.sv
// Constants, field layout and carrier types of the gate drive configuration bank.
// Assumes a 10 MHz logic clock; all cycle counts derive from its period.
package gate_drive_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Register addresses
  localparam logic [3:0] ADDR_FAULT_1 = 4'h0;
  localparam logic [3:0] ADDR_FAULT_2 = 4'h1;
  localparam logic [3:0] ADDR_DRV_CTRL = 4'h2;
  localparam logic [3:0] ADDR_HS_DRIVE = 4'h3;
  localparam logic [3:0] ADDR_LS_DRIVE = 4'h4;
  localparam logic [3:0] ADDR_OCP_CTRL = 4'h5;

  // Field positions
  localparam int LOCK_LSB = 8;
  localparam int SRC_LSB = 4;
  localparam int SNK_LSB = 0;
  localparam int CBC_BIT = 10;
  localparam int PEAK_LSB = 8;
  localparam int RETRY_BIT = 10;
  localparam int DEAD_LSB = 8;
  localparam int MODE_LSB = 6;
  localparam int FILTER_LSB = 4;
  localparam int THRESH_LSB = 0;
  localparam int CLEAR_BIT = 0;
  localparam int FLOAT_BIT = 2;
  localparam int CTRL_LOCKED_BITS = 3;
  localparam int FAULT_ANY_BIT = 10;
  localparam int FAULT_VDS_BIT = 9;
  localparam int FAULT_SEN_BIT = 10;

  // Values after reset
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [10:0] HS_RESET = 11'h3ff;
  localparam logic [10:0] LS_RESET = 11'h7ff;
  localparam logic [10:0] OCP_RESET = 11'h159;

  // Lock codes
  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;

  // Serial frame: R/W bit, 4 address bits, 11 data bits
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [4:0] SPI_HEAD_BITS = 5'h05;
  localparam logic [4:0] SPI_COUNT_MAX = 5'h1f;

  // Times
  localparam int RETRY_LONG_NS = 4000000;
  localparam int RETRY_SHORT_NS = 50000;
  localparam int FILTER_STEP_NS = 2000;
  localparam int DEAD_BASE_NS = 50;
  localparam int PEAK_BASE_NS = 500;

  // Least time to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int RETRY_LONG_CYCLES = ns_to_cycles(RETRY_LONG_NS);
  localparam int RETRY_SHORT_CYCLES = ns_to_cycles(RETRY_SHORT_NS);

  function automatic logic [2:0] dead_cycles(input logic [1:0] code);
    return 3'(ns_to_cycles(DEAD_BASE_NS << code));
  endfunction : dead_cycles

  function automatic logic [5:0] peak_cycles(input logic [1:0] code);
    return 6'(ns_to_cycles(PEAK_BASE_NS << code));
  endfunction : peak_cycles

  function automatic logic [6:0] filter_cycles(input logic [1:0] code);
    return 7'(ns_to_cycles(FILTER_STEP_NS * (int'(code) + 1)));
  endfunction : filter_cycles

  typedef enum logic [1:0] {OCP_LATCH, OCP_RETRY, OCP_REPORT, OCP_IGNORE} overcurrent_response_select_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [10:0] data;
  } spi_write_s;

  typedef struct packed {
    logic [3:0] high_side_source_strength;
    logic [3:0] high_side_sink_strength;
    logic [3:0] low_side_source_strength;
    logic [3:0] low_side_sink_strength;
    logic [5:0] peak_current_cycles;
    logic [2:0] dead_time_cycles;
    logic [3:0] drain_source_threshold_code;
  } drive_cfg_s;

endpackage : gate_drive_pkg

// ===== rtl/spi_frame_port.sv
// Serial port of the configuration bank: 16-bit frames, MSB first.
// Pins are asynchronous; SDI sampled on SCLK fall, SDO changes on SCLK rise.
`timescale 1ns/1ps
module spi_frame_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  input wire logic [10:0] rd_data,
  output logic [3:0] rd_addr,
  output logic wr_valid,
  output gate_drive_pkg::spi_write_s wr,
  output logic sdo,
  output logic sdo_oe
);
  // Bit 0 chip select, bit 1 clock, bit 2 data
  logic [2:0] s0_ff, s1_ff, s2_ff, filt_ff;
  logic sclk_prev_ff, cs_prev_ff, load_ff;
  logic [15:0] shift_in_ff;
  logic [4:0] count_ff;
  logic [10:0] out_ff;
  logic sclk_rise, sclk_fall, cs_rise, active;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s0_ff <= 3'h1;
      s1_ff <= 3'h1;
      s2_ff <= 3'h1;
    end
    else
    begin
      s0_ff <= {sdi_pin, sclk_pin, cs_n_pin};
      s1_ff <= s0_ff;
      s2_ff <= s1_ff;
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_filter
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        filt_ff[i] <= (i == 0);
      else if (s1_ff[i] == s2_ff[i])
        filt_ff[i] <= s2_ff[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclk_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end
    else
    begin
      sclk_prev_ff <= filt_ff[1];
      cs_prev_ff <= filt_ff[0];
    end
  end

  assign active = ~filt_ff[0];
  assign sclk_rise = active & filt_ff[1] & ~sclk_prev_ff;
  assign sclk_fall = active & ~filt_ff[1] & sclk_prev_ff;
  assign cs_rise = filt_ff[0] & ~cs_prev_ff;
  assign rd_addr = shift_in_ff[3:0];

  always_ff @(posedge clk)
  begin
    if (!rst_n || !active)
    begin
      shift_in_ff <= 16'h0000;
      count_ff <= 5'h00;
    end
    else if (sclk_fall)
    begin
      shift_in_ff <= {shift_in_ff[14:0], filt_ff[2]};
      if (count_ff != gate_drive_pkg::SPI_COUNT_MAX)
        count_ff <= count_ff + 5'h01;
    end
  end

  // Read data loaded once the address is complete
  always_ff @(posedge clk)
  begin
    if (!rst_n || !active)
    begin
      load_ff <= 1'b0;
      out_ff <= 11'h000;
      sdo <= 1'b0;
    end
    else
    begin
      load_ff <= sclk_fall && (count_ff == gate_drive_pkg::SPI_HEAD_BITS - 5'h01);
      if (load_ff)
        out_ff <= rd_data;
      else if (sclk_rise && count_ff >= gate_drive_pkg::SPI_HEAD_BITS)
      begin
        sdo <= out_ff[10];
        out_ff <= {out_ff[9:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_valid <= 1'b0;
      wr <= '0;
      sdo_oe <= 1'b0;
    end
    else
    begin
      sdo_oe <= active;
      wr_valid <= cs_rise && count_ff == gate_drive_pkg::SPI_FRAME_BITS && !shift_in_ff[15];
      if (cs_rise)
        wr <= shift_in_ff[14:0];
    end
  end

endmodule : spi_frame_port

// ===== tb/spi_host_model.sv
// Host controller model: sends 16-bit frames and collects read data.
// Assumes the bench clock; pins change only at its falling edge.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  localparam int HALF = 6;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  task automatic xfer(input logic [15:0] f, output logic [10:0] rd);
    logic [15:0] rx;
    int i;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (i = 15; i >= 0; i--)
    begin
      sdi = f[i];
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      rx[i] = sdo;
      sclk = 1'b0;
      repeat (HALF) @(negedge clk);
    end
    cs_n = 1'b1;
    // Released data line must not keep its last value
    sdi = ~sdi;
    rd = rx[10:0];
    // Gap also covers the commit delay after select rises
    repeat (2 * HALF) @(negedge clk);
  endtask : xfer
endmodule : spi_host_model

// ===== tb/gate_drive_ocp_config_regs_tb_top.sv
// Self-checking bench of the configuration bank against an integer model.
// Assumes the host model drives the serial pins; retry count shortened.
`timescale 1ns/1ps
module gate_drive_ocp_config_regs_tb_top;
  localparam int RL = 50;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic vds = 1'b0;
  logic sen = 1'b0;
  logic pwm = 1'b0;
  logic cs_n, sclk, sdi, sdo, sdo_oe, fault_n, inhibit, floating, locked;
  logic [10:0] rdv;
  logic [31:0] seed = 32'h76ef_4367;
  gate_drive_pkg::drive_cfg_s cfg;
  int miscompares = 0;
  int total_checks = 0;
  int mdl [8];
  bit mlock = 1'b0;
  int i, d, m;

  initial
  begin
    forever #50 clock = ~clock;
  end

  spi_host_model u_spi_host_model (.clk(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  gate_drive_ocp_config_regs #(.RETRY_LONG_CYCLES(RL)) u_gate_drive_ocp_config_regs (
    .CLOCK(clock), .RESET_N(reset_n), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .VDS_OVERCURRENT(vds), .SENSE_OVERCURRENT(sen),
    .PWM_INPUT(pwm), .FAULT_N(fault_n), .DRIVE_INHIBIT(inhibit), .OUTPUTS_FLOAT(floating),
    .BANK_LOCKED(locked), .DRIVE_CFG(cfg));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Output enable stands while the host clocks a frame
  always @(negedge clock)
  begin
    if (reset_n && !cs_n && sclk)
      chk(sdo_oe, 1);
  end

  // Model of one write, lock rules included
  task automatic wr(input int a, input int v);
    int c;
    v = v & 32'h7ff;
    c = (v >> 8) & 7;
    u_spi_host_model.xfer(16'((a << 11) | v), rdv);
    if (a == 3)
    begin
      mdl[3] = mlock ? ((mdl[3] & 32'h0ff) | (v & 32'h700)) : v;
      mlock = mlock ? (c != 3) : (c == 6);
    end
    else if (a == 2)
      mdl[2] = (mlock ? ((mdl[2] & 32'h7f8) | (v & 7)) : v) & 32'h7fe;
    else if ((a == 4 || a == 5) && !mlock)
      mdl[a] = v;
  endtask : wr

  task automatic rdc(input int a);
    u_spi_host_model.xfer(16'(32'h8000 | (a << 11)), rdv);
    chk(rdv, (a <= 5) ? mdl[a] : 0);
  endtask : rdc

  function automatic gate_drive_pkg::drive_cfg_s ecfg();
    int dt [4] = '{1, 1, 2, 4};
    return {4'(mdl[3] >> 4), 4'(mdl[3]), 4'(mdl[4] >> 4), 4'(mdl[4]),
      6'(5 << ((mdl[4] >> 8) & 3)), 3'(dt[(mdl[5] >> 8) & 3]), 4'(mdl[5])};
  endfunction : ecfg

  task automatic wait_fault(input logic v, input int n);
    int k;
    for (k = 0; k < n && fault_n !== v; k++)
      @(negedge clock);
    chk(fault_n, v);
    if (fault_n !== v)
      conclude();
  endtask : wait_fault

  // Overcurrent pulse on one of the two sources, then settle
  task automatic pulse(input bit s, input int n);
    {sen, vds} = s ? 2'b10 : 2'b01;
    cyc(n);
    {sen, vds} = 2'b00;
    cyc(6);
  endtask : pulse

  initial
  begin
    mdl = '{0, 0, 32'h000, 32'h3ff, 32'h7ff, 32'h159, 0, 0};
    cyc(8);
    reset_n = 1'b1;
    cyc(4);
    chk(locked, 0);
    chk({sdo, sdo_oe}, 2'b00);
    for (i = 2; i <= 5; i++)
      rdc(i);
    chk(cfg, ecfg());
    for (i = 0; i < 4; i++)
    begin
      d = rnd();
      if (((d >> 8) & 7) == 6)
        d = d ^ 32'h100;
      wr(3, d);
      wr(4, (rnd() & 32'h4ff) | (i << 8));
      wr(5, (rnd() & 32'h4ff) | (i << 8));
      for (m = 3; m <= 5; m++)
        rdc(m);
      chk(cfg, ecfg());
      chk(locked, 0);
    end
    wr(7, 32'h7ff);
    rdc(7);
    wr(3, 32'h6a5);
    chk(locked, 1);
    wr(4, 0);
    wr(5, 0);
    wr(3, 32'h512);
    chk(locked, 1);
    wr(2, 32'h7fc);
    chk(floating, 1);
    for (m = 2; m <= 5; m++)
      rdc(m);
    chk(cfg, ecfg());
    wr(3, 32'h300);
    chk(locked, 0);
    rdc(3);
    wr(2, 0);
    chk(floating, 0);
    for (m = 0; m < 4; m++)
    begin
      wr(5, (m << 6) | (m << 4) | 32'h109);
      pulse(m[0], 20 * (m + 1) - 5);
      chk(fault_n, 1);
      pulse(m[0], 20 * (m + 1) + 10);
      chk(fault_n, m == 3);
      chk(inhibit, m < 2);
      if (m == 1)
      begin
        cyc(25);
        chk(fault_n, 0);
        wait_fault(1, 40);
      end
      else if (m != 3)
      begin
        cyc(RL + 20);
        chk(fault_n, 0);
        wr(2, 1);
        chk(fault_n, 1);
        rdc(2);
      end
    end
    wr(4, 32'h7ff);
    wr(5, 32'h559);
    pulse(0, 50);
    chk(fault_n, 0);
    // Status read inside the short retry window
    u_spi_host_model.xfer(16'h8000, rdv);
    chk(rdv, 32'h600);
    cyc(189);
    chk(fault_n, 0);
    wait_fault(1, 150);
    pulse(0, 50);
    pwm = 1'b1;
    cyc(10);
    chk(fault_n, 1);
    pwm = 1'b0;
    wr(4, 32'h3ff);
    pulse(1, 50);
    pwm = 1'b1;
    cyc(10);
    chk(fault_n, 0);
    pwm = 1'b0;
    u_spi_host_model.xfer(16'h8800, rdv);
    chk(rdv, 32'h400);
    wait_fault(1, 600);
    // Reset in mid-run while locked
    wr(3, 32'h6ff);
    chk(locked, 1);
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    mdl = '{0, 0, 32'h000, 32'h3ff, 32'h7ff, 32'h159, 0, 0};
    mlock = 1'b0;
    cyc(4);
    chk(locked, 0);
    chk({sdo, sdo_oe}, 2'b00);
    rdc(3);
    chk(cfg, ecfg());
    conclude();
  end
endmodule : gate_drive_ocp_config_regs_tb_top
